// ---- hw/contact_filter.sv ----
// Synchroniser and debouncer for all contact inputs.
`timescale 1ns/1ps
module contact_filter #(
    parameter int DEB_CYC = remote_cmd_pkg::DEBOUNCE_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [remote_cmd_pkg::N_CONTACT-1:0] i_raw,
    contact_if.src o_ct
);
    localparam int N = remote_cmd_pkg::N_CONTACT;
    localparam int W = remote_cmd_pkg::DEB_W;
    // Two synchroniser stages; the first is read only by the second.
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    // Accepted stable level of each contact.
    logic [N-1:0] stable;
    // Time each contact has disagreed with its stable level.
    logic [W-1:0] cnt [N];

    // Bring the contacts into the clock domain.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else
        begin
            sync1 <= i_raw;
            sync2 <= sync1;
        end
    end

    // Accept a new level only after it has held for the whole debounce time.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            stable <= '0;
            o_ct.rise <= '0;
            o_ct.fall <= '0;
            for (int k = 0; k < N; k++)
                cnt[k] <= '0;
        end
        else
        begin
            for (int k = 0; k < N; k++)
            begin
                o_ct.rise[k] <= 1'b0;
                o_ct.fall[k] <= 1'b0;
                if (sync2[k] == stable[k])
                    cnt[k] <= '0;
                else if (cnt[k] == W'(DEB_CYC - 1))
                begin
                    // The new level has settled; flip and mark the edge.
                    stable[k] <= sync2[k];
                    o_ct.rise[k] <= sync2[k];
                    o_ct.fall[k] <= ~sync2[k];
                    cnt[k] <= '0;
                end
                else
                    cnt[k] <= cnt[k] + 1'b1;
            end
        end
    end

    assign o_ct.level = stable;
endmodule

// ---- hw/contact_if.sv ----
// Interface carrying filtered contact levels and their edges.
`timescale 1ns/1ps
interface contact_if;
    // Debounced contact levels, one means closed.
    logic [remote_cmd_pkg::N_CONTACT-1:0] level;
    // One-cycle pulses on closing and on opening.
    logic [remote_cmd_pkg::N_CONTACT-1:0] rise;
    logic [remote_cmd_pkg::N_CONTACT-1:0] fall;
    modport src (output level, output rise, output fall);
    modport snk (input level, input rise, input fall);
endinterface

// ---- hw/pulse_qualifier.sv ----
// Measures the closed interval of one contact and flags long enough pulses.
`timescale 1ns/1ps
module pulse_qualifier #(
    parameter int IDX = 0,
    parameter int MIN_CYC = remote_cmd_pkg::MIN_PULSE_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    contact_if.snk i_ct,
    output logic o_pulse
);
    localparam int W = remote_cmd_pkg::PULSE_W;
    // Closed time, saturating one past the minimum so long holds cannot wrap.
    logic [W-1:0] closed_cnt;

    // Count while closed; on opening, qualify the interval and restart.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            closed_cnt <= '0;
            o_pulse <= 1'b0;
        end
        else
        begin
            // A pulse counts only when it was strictly longer than the minimum.
            o_pulse <= i_ct.fall[IDX] && (closed_cnt > W'(MIN_CYC));
            if (!i_ct.level[IDX])
                closed_cnt <= '0;
            else if (closed_cnt <= W'(MIN_CYC))
                closed_cnt <= closed_cnt + 1'b1;
        end
    end

    // A qualified pulse follows an opening edge after a long enough hold.
    a_pulse_width: assert property (@(posedge i_clk) disable iff (i_rst)
        o_pulse |-> $past(i_ct.fall[IDX]) && ($past(closed_cnt) > W'(MIN_CYC)))
        else $error("pulse flagged without a long enough closed interval");
endmodule

// ---- hw/remote_cmd_pkg.sv ----
// Package with constants shared by the remote contact command logic.
package remote_cmd_pkg;
    // System clock rate in hertz.
    localparam int CLK_HZ = 100_000_000;
    // Cycles per millisecond at the system clock rate.
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    // Contact debounce settling time in milliseconds.
    localparam int DEBOUNCE_MS = 10;
    // Debounce time in clock cycles.
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
    // Minimum closed interval of a start or stop pulse in milliseconds.
    localparam int MIN_PULSE_MS = 500;
    // Minimum pulse interval in clock cycles.
    localparam int MIN_PULSE_CYC = MIN_PULSE_MS * CYC_PER_MS;
    // Counter widths for the debounce and pulse timers.
    localparam int DEB_W = 20;
    localparam int PULSE_W = 26;
    // Number of contact inputs and their positions in the contact vector.
    localparam int N_CONTACT = 10;
    localparam int C_START = 0;
    localparam int C_STOP = 1;
    localparam int C_INHIBIT = 2;
    localparam int C_SPEED = 3;
    localparam int SPEED_W = 3;
    localparam int C_REMOTE_EN = 6;
    localparam int C_EXT_RESET = 7;
    localparam int C_DOOR_RESET = 8;
    localparam int C_SWITCH_ACT = 9;
    // Register bus widths and offsets.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] OFS_CONFIG = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_SPEED = 4'h2;
    localparam logic [3:0] OFS_CONTACT = 4'h3;
    // Configuration register fields and reset value.
    localparam int CFG_REMOTE = 0;
    localparam int CFG_SEL_BY_REMOTE = 1;
    localparam int CFG_PULSE_MODE = 2;
    localparam int CFG_OPEN_LOOP = 3;
    localparam int CFG_DI_SETTING = 4;
    localparam int CFG_W = 5;
    localparam logic [4:0] CFG_RESET = 5'h00;
    // Status register fields.
    localparam int ST_RUN = 0;
    localparam int ST_REVERSE = 1;
    localparam int ST_INHIBIT = 2;
    localparam int ST_FAULT = 3;
    localparam int ST_REMOTE = 4;
    localparam int ST_SPEED_VALID = 5;
    // Run command states, one-hot.
    typedef enum logic [2:0] {
        RUN_STOPPED = 3'h1,
        RUN_FORWARD = 3'h2,
        RUN_REVERSE = 3'h4
    } run_state_t;
endpackage

// ---- hw/remote_run_command_inputs.sv ----
// Top of the remote contact command interpreter with its register port.
`timescale 1ns/1ps
module remote_run_command_inputs #(
    parameter int DEBOUNCE_CYCLES = remote_cmd_pkg::DEBOUNCE_CYC,
    parameter int MIN_PULSE_CYCLES = remote_cmd_pkg::MIN_PULSE_CYC
) (
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_START_CONTACT,
    input wire logic I_STOP_CONTACT,
    input wire logic I_OUTPUT_INHIBIT_CONTACT,
    input wire logic [2:0] I_SPEED_CONTACT,
    input wire logic I_REMOTE_ENABLE_CONTACT,
    input wire logic I_EXT_RESET_CONTACT,
    input wire logic I_DOOR_RESET_BUTTON,
    input wire logic I_SWITCH_ACTIVATE_CONTACT,
    input wire logic I_FAULT_EVENT,
    input wire logic I_FAULT_CAUSE_ACTIVE,
    input wire logic [3:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [7:0] O_REG_RDATA,
    output logic O_RUN,
    output logic O_REVERSE,
    output logic O_OUTPUT_INHIBIT,
    output logic [2:0] O_SPEED_SEL,
    output logic O_SPEED_SEL_VALID,
    output logic O_REMOTE_ACTIVE,
    output logic O_FAULT_LATCHED,
    output logic O_FAULT_RESET,
    output logic O_SYNC_SWITCH_REQ
);
    // Filtered contact levels and edges.
    contact_if ct ();
    // All raw contact pins gathered in their package positions.
    logic [remote_cmd_pkg::N_CONTACT-1:0] raw;
    // Qualified start and stop pulses from the pulse timers.
    logic start_pulse;
    logic stop_pulse;
    // Software configuration bits.
    logic [remote_cmd_pkg::CFG_W-1:0] cfg;
    // Current run command and its next value.
    remote_cmd_pkg::run_state_t run_state;
    remote_cmd_pkg::run_state_t next_run_state;
    // Derived command conditions.
    logic remote_active;
    logic inhibit_ok;
    logic pulse_mode;
    logic speed_gate;
    logic reset_req;
    // Latched fault.
    logic fault;

    // Pack the pins; the order follows the contact positions.
    assign raw = {I_SWITCH_ACTIVATE_CONTACT, I_DOOR_RESET_BUTTON, I_EXT_RESET_CONTACT,
                  I_REMOTE_ENABLE_CONTACT, I_SPEED_CONTACT, I_OUTPUT_INHIBIT_CONTACT,
                  I_STOP_CONTACT, I_START_CONTACT};

    // Two-stage synchronisers and debouncers for every contact.
    contact_filter #(
        .DEB_CYC(DEBOUNCE_CYCLES)
    ) u_filter (
        .i_clk(I_SYS_CLK),
        .i_rst(I_SYS_RST),
        .i_raw(raw),
        .o_ct(ct.src)
    );

    // Closed-interval timer for the start contact.
    pulse_qualifier #(
        .IDX(remote_cmd_pkg::C_START),
        .MIN_CYC(MIN_PULSE_CYCLES)
    ) u_start_pulse (
        .i_clk(I_SYS_CLK),
        .i_rst(I_SYS_RST),
        .i_ct(ct.snk),
        .o_pulse(start_pulse)
    );

    // Closed-interval timer for the stop contact.
    pulse_qualifier #(
        .IDX(remote_cmd_pkg::C_STOP),
        .MIN_CYC(MIN_PULSE_CYCLES)
    ) u_stop_pulse (
        .i_clk(I_SYS_CLK),
        .i_rst(I_SYS_RST),
        .i_ct(ct.snk),
        .o_pulse(stop_pulse)
    );

    // Control source: the remote enable contact decides when so configured.
    assign remote_active = cfg[remote_cmd_pkg::CFG_SEL_BY_REMOTE]
                           ? ct.level[remote_cmd_pkg::C_REMOTE_EN]
                           : cfg[remote_cmd_pkg::CFG_REMOTE];
    // The inhibit contact must be closed for the output to run.
    assign inhibit_ok = ct.level[remote_cmd_pkg::C_INHIBIT];
    // Interpretation of start and stop comes from the stored mode bit.
    assign pulse_mode = cfg[remote_cmd_pkg::CFG_PULSE_MODE];
    // Speed contacts are read only in open loop with digital input setting.
    assign speed_gate = cfg[remote_cmd_pkg::CFG_OPEN_LOOP]
                        && cfg[remote_cmd_pkg::CFG_DI_SETTING];
    // A closing of either reset source is one and the same request.
    assign reset_req = ct.rise[remote_cmd_pkg::C_EXT_RESET]
                       || ct.rise[remote_cmd_pkg::C_DOOR_RESET];

    // Next run command; reset requests take no part in it.
    always_comb
    begin
        next_run_state = run_state;
        if (!remote_active || !inhibit_ok)
            // Contacts are ignored off remote; inhibit lets the motor coast.
            next_run_state = remote_cmd_pkg::RUN_STOPPED;
        else if (!pulse_mode)
        begin
            // Level mode follows the contacts; both closed is treated as stop.
            if (ct.level[remote_cmd_pkg::C_START] && !ct.level[remote_cmd_pkg::C_STOP])
                next_run_state = remote_cmd_pkg::RUN_FORWARD;
            else if (ct.level[remote_cmd_pkg::C_STOP] && !ct.level[remote_cmd_pkg::C_START])
                next_run_state = remote_cmd_pkg::RUN_REVERSE;
            else
                next_run_state = remote_cmd_pkg::RUN_STOPPED;
        end
        else
        begin
            unique case (run_state)
                remote_cmd_pkg::RUN_STOPPED:
                begin
                    // A qualified start pulse starts forward unless stop pulses too.
                    if (start_pulse && !stop_pulse)
                        next_run_state = remote_cmd_pkg::RUN_FORWARD;
                end
                remote_cmd_pkg::RUN_FORWARD, remote_cmd_pkg::RUN_REVERSE:
                begin
                    // A qualified stop pulse stops whatever is running.
                    if (stop_pulse)
                        next_run_state = remote_cmd_pkg::RUN_STOPPED;
                end
                default:
                    next_run_state = remote_cmd_pkg::RUN_STOPPED;
            endcase
        end
    end

    // Hold the run command.
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_SYS_RST)
            run_state <= remote_cmd_pkg::RUN_STOPPED;
        else
            run_state <= next_run_state;
    end

    // Registered command outputs other than run state.
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_SYS_RST)
        begin
            O_OUTPUT_INHIBIT <= 1'b1;
            O_SPEED_SEL <= '0;
            O_SPEED_SEL_VALID <= 1'b0;
            O_REMOTE_ACTIVE <= 1'b0;
            O_SYNC_SWITCH_REQ <= 1'b0;
        end
        else
        begin
            O_OUTPUT_INHIBIT <= !inhibit_ok;
            // Speed selection is zero and invalid while it may not be read.
            O_SPEED_SEL <= speed_gate
                ? ct.level[remote_cmd_pkg::C_SPEED +: remote_cmd_pkg::SPEED_W] : '0;
            O_SPEED_SEL_VALID <= speed_gate;
            O_REMOTE_ACTIVE <= remote_active;
            // Switch activate goes to the transfer logic and nowhere else.
            O_SYNC_SWITCH_REQ <= ct.level[remote_cmd_pkg::C_SWITCH_ACT];
        end
    end

    // Fault latch; a new fault wins over a reset in the same cycle.
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_SYS_RST)
        begin
            fault <= 1'b0;
            O_FAULT_RESET <= 1'b0;
        end
        else
        begin
            // The reset pulse appears only when a fault really clears.
            O_FAULT_RESET <= reset_req && fault && !I_FAULT_CAUSE_ACTIVE
                             && !I_FAULT_EVENT;
            if (I_FAULT_EVENT)
                fault <= 1'b1;
            else if (reset_req && !I_FAULT_CAUSE_ACTIVE)
                fault <= 1'b0;
        end
    end

    // Register writes: only the configuration register is writable.
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_SYS_RST)
            cfg <= remote_cmd_pkg::CFG_RESET;
        else if (I_REG_WR && I_REG_ADDR == remote_cmd_pkg::OFS_CONFIG)
            cfg <= I_REG_WDATA[remote_cmd_pkg::CFG_W-1:0];
    end

    // Register reads: data stand one cycle after the strobe, zero otherwise.
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_SYS_RST || !I_REG_RD)
            O_REG_RDATA <= '0;
        else
        begin
            unique case (I_REG_ADDR)
                remote_cmd_pkg::OFS_CONFIG:
                    O_REG_RDATA <= 8'(cfg);
                remote_cmd_pkg::OFS_STATUS:
                    O_REG_RDATA <= {2'h0, O_SPEED_SEL_VALID, O_REMOTE_ACTIVE, fault,
                                    O_OUTPUT_INHIBIT, O_REVERSE, O_RUN};
                remote_cmd_pkg::OFS_SPEED:
                    O_REG_RDATA <= 8'(O_SPEED_SEL);
                remote_cmd_pkg::OFS_CONTACT:
                    O_REG_RDATA <= ct.level[7:0];
                default:
                    // Unmapped addresses read as zero.
                    O_REG_RDATA <= '0;
            endcase
        end
    end

    // Run outputs come straight from the state flip-flops.
    assign O_RUN = (run_state != remote_cmd_pkg::RUN_STOPPED);
    assign O_REVERSE = (run_state == remote_cmd_pkg::RUN_REVERSE);
    assign O_FAULT_LATCHED = fault;

    // Checks on the command behaviour.
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);

    // Remote control in pulse mode with output allowed; the pulses are tested by each assertion.
    sequence s_pulse_ready;
        remote_active && pulse_mode && inhibit_ok;
    endsequence

    a_ignore_local: assert property (!remote_active |=> !O_RUN)
        else $error("run command present while not under remote control");
    a_level_fwd: assert property (remote_active && !pulse_mode && inhibit_ok
        && ct.level[remote_cmd_pkg::C_START] && !ct.level[remote_cmd_pkg::C_STOP]
        |=> O_RUN && !O_REVERSE)
        else $error("level start did not run forward");
    a_level_rev: assert property (remote_active && !pulse_mode && inhibit_ok
        && ct.level[remote_cmd_pkg::C_STOP] && !ct.level[remote_cmd_pkg::C_START]
        |=> O_RUN && O_REVERSE)
        else $error("level stop did not run reverse");
    a_pulse_start: assert property (s_pulse_ready ##0 (start_pulse && !stop_pulse)
        |=> O_RUN)
        else $error("pulse start did not start the drive");
    a_pulse_stop: assert property (s_pulse_ready ##0 stop_pulse |=> !O_RUN)
        else $error("pulse stop did not stop the drive");
    a_inhibit_coast: assert property (!inhibit_ok |=> O_OUTPUT_INHIBIT && !O_RUN)
        else $error("open inhibit contact did not stop the output");
    a_speed_gate: assert property (!speed_gate |=> !O_SPEED_SEL_VALID
        && O_SPEED_SEL == 3'h0)
        else $error("speed contacts read outside open loop input setting");
    a_reset_keeps_run: assert property (reset_req && O_RUN && remote_active && inhibit_ok
        && pulse_mode && !stop_pulse |=> O_RUN)
        else $error("reset request stopped a running drive");
    a_reset_no_fault: assert property (reset_req && !fault && !I_FAULT_EVENT
        |=> !fault && !O_FAULT_RESET)
        else $error("reset without a fault changed the fault state");
    a_fault_clear: assert property (reset_req && fault && !I_FAULT_CAUSE_ACTIVE
        && !I_FAULT_EVENT |=> !fault && O_FAULT_RESET)
        else $error("reset did not clear a removed fault");
endmodule

// ---- tb/contact_field.sv ----
// Behavioural model of the field contacts wired to the upper remote terminal strip.
`timescale 1ns/1ps
module contact_field (
    input wire logic i_clk,
    input wire logic [remote_cmd_pkg::N_CONTACT-1:0] i_close,
    output logic [remote_cmd_pkg::N_CONTACT-1:0] o_pin
);
    // Commanded contact states of the previous cycle.
    logic [remote_cmd_pkg::N_CONTACT-1:0] last = '0;
    // Contacts that moved at the most recent change.
    logic [remote_cmd_pkg::N_CONTACT-1:0] moved = '0;
    // Remaining cycles of contact bounce after a change.
    logic [1:0] chatter = 2'h0;

    // Real dry contacts bounce, so every change chatters for three cycles before settling.
    always_ff @(posedge i_clk)
    begin
        if (i_close != last)
        begin
            moved <= i_close ^ last;
            chatter <= 2'h3;
        end
        else if (chatter != 2'h0)
        begin
            chatter <= chatter - 2'h1;
        end
        last <= i_close;
    end

    // The bouncing contacts swing back to their old level on odd chatter counts.
    assign o_pin = i_close ^ (moved & {remote_cmd_pkg::N_CONTACT{chatter[0]}});
endmodule

// ---- tb/remote_run_command_inputs_bench.sv ----
// Self-checking bench for the remote contact command interpreter.
`timescale 1ns/1ps
module remote_run_command_inputs_bench;
    // Shortened debounce and minimum pulse counts.
    localparam int DEB = 4;
    localparam int MINP = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    // Contact order: start, stop, inhibit, speed 1..3, remote enable, ext reset, door, switch.
    logic [9:0] close_cmd = 10'h004;
    logic [9:0] pins;
    logic fault_ev = 1'b0;
    logic cause = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [2:0] spd;
    logic run, rev, inh, spd_ok, rem, flt, frst, sw;
    // Outputs gathered so that one wait task serves them all.
    logic [6:0] outs;
    int mismatches = 0;
    int tests_run = 0;
    int clears = 0;
    logic [7:0] d;

    assign outs = {sw, flt, rem, spd_ok, inh, rev, run};

    contact_field field (.i_clk(clk), .i_close(close_cmd), .o_pin(pins));

    remote_run_command_inputs #(.DEBOUNCE_CYCLES(DEB), .MIN_PULSE_CYCLES(MINP)) dut (
        .I_SYS_CLK(clk), .I_SYS_RST(rst), .I_START_CONTACT(pins[0]), .I_STOP_CONTACT(pins[1]),
        .I_OUTPUT_INHIBIT_CONTACT(pins[2]), .I_SPEED_CONTACT(pins[5:3]),
        .I_REMOTE_ENABLE_CONTACT(pins[6]), .I_EXT_RESET_CONTACT(pins[7]),
        .I_DOOR_RESET_BUTTON(pins[8]), .I_SWITCH_ACTIVATE_CONTACT(pins[9]),
        .I_FAULT_EVENT(fault_ev), .I_FAULT_CAUSE_ACTIVE(cause), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .O_RUN(run),
        .O_REVERSE(rev), .O_OUTPUT_INHIBIT(inh), .O_SPEED_SEL(spd), .O_SPEED_SEL_VALID(spd_ok),
        .O_REMOTE_ACTIVE(rem), .O_FAULT_LATCHED(flt), .O_FAULT_RESET(frst),
        .O_SYNC_SWITCH_REQ(sw));

    // Free-running system clock.
    initial
    begin
        forever #5 clk = ~clk;
    end

    // Counts fault-clear pulses, which last only one cycle.
    always @(posedge clk)
    begin
        if (frst === 1'b1)
            clears <= clears + 1;
    end

    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (mismatches == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Compares one seen value against its expectation.
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Waits a bounded time for one output to reach a level.
    task automatic await(input int idx, input logic val, input string what);
        int n;
        n = 0;
        while (outs[idx] !== val && n < 60)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check(what, {7'h00, outs[idx]}, {7'h00, val});
        // Only a wait that really ran out ends the run early.
        if (outs[idx] !== val)
            stop_test();
    endtask

    // One register write cycle.
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // One register read; the data stand only in the cycle after the strobe.
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    // Moves one field contact.
    task automatic contact(input int idx, input logic val);
        @(posedge clk);
        close_cmd[idx] <= val;
    endtask

    // Lets a number of cycles pass.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Closes a contact briefly, as a push button would.
    task automatic press(input int idx);
        contact(idx, 1'b1);
        settle(15);
        contact(idx, 1'b0);
        settle(15);
    endtask

    // Values right after reset, refused writes and an unmapped read.
    task automatic t_reset();
        check("inhibit after reset", {7'h00, inh}, 8'h01);
        check("run after reset", {7'h00, run}, 8'h00);
        reg_wr(4'h1, 8'hff);
        reg_rd(4'h0, d);
        check("config", d, 8'h00);
        reg_rd(4'hf, d);
        check("unmapped", d, 8'h00);
        await(2, 1'b0, "inhibit released");
    endtask

    // Level mode: ignored under local control, forward and reverse under remote.
    task automatic t_level();
        contact(0, 1'b1);
        settle(25);
        check("run local", {7'h00, run}, 8'h00);
        reg_wr(4'h0, 8'h01);
        await(0, 1'b1, "run forward");
        check("reverse", {7'h00, rev}, 8'h00);
        contact(0, 1'b0);
        await(0, 1'b0, "stop forward");
        contact(1, 1'b1);
        await(1, 1'b1, "run reverse");
        reg_rd(4'h1, d);
        check("status reverse", d, 8'h13);
        contact(1, 1'b0);
        await(0, 1'b0, "stop reverse");
    endtask

    // Opening the inhibit contact drops a running drive.
    task automatic t_inhibit();
        contact(0, 1'b1);
        await(0, 1'b1, "run");
        contact(2, 1'b0);
        await(2, 1'b1, "inhibit");
        check("run inhibited", {7'h00, run}, 8'h00);
        contact(0, 1'b0);
        contact(2, 1'b1);
        await(2, 1'b0, "inhibit cleared");
    endtask

    // Pulse mode: width limit, reset while running, stop pulse.
    task automatic t_pulse();
        reg_wr(4'h0, 8'h05);
        contact(0, 1'b1);
        settle(MINP / 2);
        contact(0, 1'b0);
        settle(30);
        check("short start", {7'h00, run}, 8'h00);
        contact(0, 1'b1);
        settle(MINP + 20);
        check("start still closed", {7'h00, run}, 8'h00);
        contact(0, 1'b0);
        await(0, 1'b1, "long start");
        press(8);
        check("run after reset", {7'h00, run}, 8'h01);
        check("no fault", {7'h00, flt}, 8'h00);
        check("no clear pulse", clears[7:0], 8'h00);
        contact(1, 1'b1);
        settle(MINP + 20);
        check("stop still closed", {7'h00, run}, 8'h01);
        contact(1, 1'b0);
        await(0, 1'b0, "long stop");
    endtask

    // Fault latch: kept while the cause stands, cleared by either reset source.
    task automatic t_fault();
        @(posedge clk);
        fault_ev <= 1'b1;
        cause <= 1'b1;
        @(posedge clk);
        fault_ev <= 1'b0;
        await(5, 1'b1, "fault latched");
        press(7);
        check("fault with cause", {7'h00, flt}, 8'h01);
        @(posedge clk);
        cause <= 1'b0;
        press(7);
        check("fault after ext reset", {7'h00, flt}, 8'h00);
        check("clear pulses", clears[7:0], 8'h01);
        @(posedge clk);
        fault_ev <= 1'b1;
        @(posedge clk);
        fault_ev <= 1'b0;
        await(5, 1'b1, "fault again");
        press(8);
        check("fault after door", {7'h00, flt}, 8'h00);
        check("clear pulses", clears[7:0], 8'h02);
    endtask

    // Speed contacts pass only in open loop with the digital input setting.
    task automatic t_speed();
        @(posedge clk);
        close_cmd[5:3] <= 3'b101;
        reg_wr(4'h0, 8'h18);
        settle(25);
        check("speed", {5'h00, spd}, 8'h05);
        check("speed valid", {7'h00, spd_ok}, 8'h01);
        reg_rd(4'h2, d);
        check("speed reg", d, 8'h05);
        settle(1);
        check("read data cleared", rdata, 8'h00);
        reg_rd(4'h3, d);
        check("contact reg", d, 8'h2c);
        reg_wr(4'h0, 8'h08);
        settle(5);
        check("speed gated", {5'h00, spd}, 8'h00);
        check("speed invalid", {7'h00, spd_ok}, 8'h00);
    endtask

    // Remote enable contact selects remote control; switch activate leaves run alone.
    task automatic t_remote();
        reg_wr(4'h0, 8'h02);
        settle(5);
        check("remote off", {7'h00, rem}, 8'h00);
        contact(6, 1'b1);
        await(4, 1'b1, "remote on");
        contact(0, 1'b1);
        await(0, 1'b1, "run by remote");
        contact(9, 1'b1);
        await(6, 1'b1, "switch request");
        check("run with switch", {7'h00, run}, 8'h01);
        contact(6, 1'b0);
        await(4, 1'b0, "remote dropped");
        check("run without remote", {7'h00, run}, 8'h00);
    endtask

    // Main sequence.
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_level();
        t_inhibit();
        t_pulse();
        t_fault();
        t_speed();
        t_remote();
        stop_test();
    end
endmodule
